// ==== logic/gds_pkg.sv ====
// Constants shared by the gate drive sequencer files.
package gds_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [4:0] OFS_CTRL    = 5'h00;
  localparam logic [4:0] OFS_CURRENT = 5'h04;
  localparam logic [4:0] OFS_TIMING  = 5'h08;
  localparam logic [4:0] OFS_PDR     = 5'h0c;
  localparam logic [4:0] OFS_STATUS  = 5'h10;
  localparam logic [4:0] OFS_DELAY   = 5'h14;

  // ==========================================================================
  // Field positions
  localparam int CTRL_EN       = 0;
  localparam int CTRL_HB_MODE  = 1;
  localparam int CTRL_PDR_EN   = 2;
  localparam int CTRL_POST_EN  = 3;
  localparam int CTRL_SEL      = 4;
  localparam int CTRL_HS_LO    = 5;
  localparam int CTRL_LS_LO    = 6;
  localparam int CUR_HS_SRC    = 0;
  localparam int CUR_HS_SNK    = 4;
  localparam int CUR_LS_SRC    = 8;
  localparam int CUR_LS_SNK    = 12;
  localparam int TIM_DRIVE     = 0;
  localparam int TIM_DEAD      = 8;
  localparam int PDR_TARGET    = 0;
  localparam int PDR_GAIN      = 16;
  localparam int PDR_INIT_CHR  = 20;
  localparam int PDR_MAX       = 24;
  localparam int PDR_INIT_DCHR = 28;
  localparam int STAT_FLT_HS   = 0;
  localparam int STAT_FLT_LS   = 1;
  localparam int STAT_LOCK     = 2;
  localparam int STAT_PRE_CHR  = 4;
  localparam int STAT_PRE_DCHR = 8;
  localparam int DLY_OFF       = 16;

  // ==========================================================================
  // Reset values
  localparam logic [6:0]  CTRL_RESET    = 7'h00;
  localparam logic [15:0] CURRENT_RESET = 16'h8888;
  localparam logic [15:0] TIMING_RESET  = 16'h000a;
  localparam logic [31:0] PDR_RESET     = 32'h4f4200a0;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS    = 5;
  localparam int DRIVE_UNIT_NS    = 100;
  localparam int DRIVE_UNIT_CYCLES = DRIVE_UNIT_NS / CLK_PERIOD_NS;
  localparam int ERR_SHIFT        = 4;

  // ==========================================================================
  // Gate currents in steps of 5 uA, index 15 first.
  localparam logic [15:0][13:0] CUR_NORMAL = {
    14'h3070, 14'h2580, 14'h1838, 14'h12c0, 14'h0fa0, 14'h0c80, 14'h0960, 14'h0640,
    14'h0578, 14'h04b0, 14'h03e8, 14'h0320, 14'h0258, 14'h0190, 14'h00c8, 14'h0064};
  localparam logic [15:0][13:0] CUR_LOW = {
    14'h01cc, 14'h0168, 14'h0140, 14'h0118, 14'h00f0, 14'h00c8, 14'h00aa, 14'h0091,
    14'h0078, 14'h0052, 14'h0046, 14'h003a, 14'h002e, 14'h0022, 14'h0016, 14'h000a};
  // Hold and strong pulldown levels are fixed in the analog stage; plain defaults.
  localparam logic [13:0] HOLD_CURRENT   = 14'h0190;
  localparam logic [13:0] STRONG_CURRENT = 14'h3070;
  localparam logic [3:0]  POST_CODE      = 4'hf;

endpackage

// ==== logic/gds_gate_driver.sv ====
// One gate driver: peak drive window, hold or strong pulldown, gate check.
`timescale 1ns/1ps
module gds_gate_driver #(
  parameter int TW = 16
) (
  input  wire logic          clk_sys,      // System clock.
  input  wire logic          resetn,       // Asynchronous reset, active low.
  input  wire logic          turn_on,      // Switch-on command pulse.
  input  wire logic          turn_off,     // Switch-off command pulse.
  input  wire logic          gate_high,    // Gate voltage monitor, synchronised.
  input  wire logic          low_range,    // Selects the low current table.
  input  wire logic [3:0]    src_code,     // Source current code.
  input  wire logic [3:0]    snk_code,     // Sink current code.
  input  wire logic [TW-1:0] drive_cycles, // Drive duration in cycles.
  input  wire logic          opp_switching, // Opposite switch is being turned on.
  output logic      [13:0]   gate_current, // Current in 5 uA steps.
  output logic               pull_up,      // High while sourcing.
  output logic               in_drive,     // Peak window, also fault blanking.
  output logic               fault_pulse   // One cycle on gate fault.
);

  typedef enum logic [1:0] {DRV_OFF, DRV_SRC, DRV_HOLD, DRV_SNK} gds_drv_type;

  gds_drv_type   state;
  gds_drv_type   next_state;
  logic [TW-1:0] timer;
  logic [13:0]   next_current;

  wire          peak      = (state == DRV_SRC) || (state == DRV_SNK);
  wire          expire    = peak && (timer == TW'(1)) && !turn_on && !turn_off;
  wire [TW-1:0] load_val  = (drive_cycles == '0) ? TW'(1) : drive_cycles;
  wire [3:0]    sel_code  = (next_state == DRV_SRC) ? src_code : snk_code;
  wire [13:0]   table_val = low_range ? gds_pkg::CUR_LOW[sel_code] : gds_pkg::CUR_NORMAL[sel_code];
  wire          bad_gate  = (state == DRV_SRC) ? !gate_high : gate_high;

  always_comb begin
    next_state = state;
    if (turn_on) begin
      next_state = DRV_SRC;
    end else if (turn_off) begin
      next_state = DRV_SNK;
    end else if (expire) begin
      next_state = (state == DRV_SRC) ? DRV_HOLD : DRV_OFF;
    end
  end

  always_comb begin
    case (next_state)
      DRV_SRC:  next_current = table_val;
      DRV_SNK:  next_current = opp_switching ? gds_pkg::STRONG_CURRENT : table_val;
      DRV_HOLD: next_current = gds_pkg::HOLD_CURRENT;
      default:  next_current = gds_pkg::STRONG_CURRENT;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state        <= DRV_OFF;
      timer        <= '0;
      gate_current <= gds_pkg::STRONG_CURRENT;
      pull_up      <= 1'b0;
      in_drive     <= 1'b0;
      fault_pulse  <= 1'b0;
    end else begin
      state        <= next_state;
      timer        <= (turn_on || turn_off) ? load_val : (peak ? timer - TW'(1) : timer);
      gate_current <= next_current;
      pull_up      <= (next_state == DRV_SRC) || (next_state == DRV_HOLD);
      in_drive     <= (next_state == DRV_SRC) || (next_state == DRV_SNK);
      fault_pulse  <= expire && bad_gate;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence src_expiring;
    state == DRV_SRC && expire;
  endsequence

  peak_start_a: assert property (turn_on |=> state == DRV_SRC && in_drive)
    else $error("drive window did not open on command");
  hold_fall_a: assert property (src_expiring |=> state == DRV_HOLD && gate_current == gds_pkg::HOLD_CURRENT)
    else $error("no hold current after drive window");
  gate_check_a: assert property (src_expiring ##0 !gate_high |=> fault_pulse)
    else $error("missed gate fault at window end");
  early_end_a: assert property (state == DRV_SRC && turn_off |=> state == DRV_SNK && !fault_pulse)
    else $error("new command did not end drive window");

endmodule

// ==== logic/gds_sequencer.sv ====
// Half-bridge gate drive sequencer with register slave and delay loop.
// Behaviour
// - Decode 4-bit codes to sixteen current levels.
// - Low range bit selects small current table.
// - Programmed peak current only during drive duration.
// - Fall back to hold current after duration.
// - Enable switch only after opposite gate off.
// - Optional programmable dead time before enabling.
// - Off driver holds strong pulldown meanwhile.
// - Check gate monitor at duration end; flag.
// - New command ends drive duration early.
// - Delay loop only in half-bridge serial mode.
// - Compare turn-on delay, adapt pre-charge current.
// - Mirror loop adapts pre-discharge sink current.
// - Boost current after the Miller region.
// - Delay loop runs only when enabled.
// - Select bit picks adaptive bridge of pair.
// - Drive duration blanks gate and drain monitors.
// - Adapted currents clamped to programmed maximum.
// - Loop starts from programmed initial current.
//
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module gds_sequencer #(
  parameter int TW             = 16,   // Width of the drive timer.
  parameter int BRIDGE_INDEX   = 0,    // Position of this bridge in its pair.
  parameter bit SERIAL_VARIANT = 1'b1  // Allows the delay loop to run; the register interface is always present.
) (
  input  wire logic        clk_sys,          // System clock, 200 MHz.
  input  wire logic        resetn,           // Asynchronous reset, active low.
  input  wire logic [4:0]  avs_address,      // Byte address.
  input  wire logic        avs_read,         // Read request.
  input  wire logic        avs_write,        // Write request.
  input  wire logic [31:0] avs_writedata,    // Write data.
  input  wire logic [3:0]  avs_byteenable,   // Byte lanes of a write.
  output logic      [31:0] avs_readdata,     // Read data.
  output logic             avs_waitrequest,  // Low for one cycle to answer.
  input  wire logic        pwm_in,           // PWM command pin, high turns on high side.
  input  wire logic        vgs_high_on,      // High-side gate above threshold.
  input  wire logic        vgs_low_on,       // Low-side gate above threshold.
  input  wire logic        sh_above_low,     // Switch node above low threshold.
  input  wire logic        sh_above_high,    // Switch node above high threshold.
  output logic      [13:0] hs_gate_current,  // High-side current, 5 uA steps.
  output logic             hs_pull_up,       // High-side sourcing.
  output logic             hs_blank,         // High-side monitor blanking.
  output logic      [13:0] ls_gate_current,  // Low-side current, 5 uA steps.
  output logic             ls_pull_up,       // Low-side sourcing.
  output logic             ls_blank,         // Low-side monitor blanking.
  output logic             gate_fault_hs,    // Sticky high-side gate fault.
  output logic             gate_fault_ls     // Sticky low-side gate fault.
);

  typedef enum logic [1:0] {BR_IDLE, BR_BREAK, BR_DEAD, BR_ON} gds_bridge_type;

  // ==========================================================================
  // Pin synchronisers
  logic [3:0] sync_a;
  logic [3:0] sync_b;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end else begin
      sync_a <= {sh_above_high, sh_above_low, vgs_low_on, vgs_high_on};
      sync_b <= sync_a;
    end
  end

  logic pwm_a;
  logic pwm_s;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pwm_a <= 1'b0;
      pwm_s <= 1'b0;
    end else begin
      pwm_a <= pwm_in;
      pwm_s <= pwm_a;
    end
  end

  wire vgs_hi_s = sync_b[0];
  wire vgs_lo_s = sync_b[1];
  wire sh_lo_s  = sync_b[2];
  wire sh_hi_s  = sync_b[3];

  // ==========================================================================
  // Register slave
  logic [6:0]  ctrl;
  logic [15:0] cur_cfg;
  logic [15:0] tim_cfg;
  logic [31:0] pdr_cfg;
  logic [15:0] last_ton;
  logic [15:0] last_toff;
  logic [3:0]  pre_chr;
  logic [3:0]  pre_dchr;
  logic        locked;

  wire [31:0] wmask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire        wr_go  = avs_write && !avs_waitrequest;
  wire        sel_ctl = avs_address[4:2] == gds_pkg::OFS_CTRL[4:2];
  wire        sel_cur = avs_address[4:2] == gds_pkg::OFS_CURRENT[4:2];
  wire        sel_tim = avs_address[4:2] == gds_pkg::OFS_TIMING[4:2];
  wire        sel_pdr = avs_address[4:2] == gds_pkg::OFS_PDR[4:2];
  wire        sel_sts = avs_address[4:2] == gds_pkg::OFS_STATUS[4:2];
  wire        sel_dly = avs_address[4:2] == gds_pkg::OFS_DELAY[4:2];
  wire [31:0] wr_ctl = ({25'h0, ctrl} & ~wmask) | (avs_writedata & wmask);
  wire [31:0] wr_cur = ({16'h0, cur_cfg} & ~wmask) | (avs_writedata & wmask);
  wire [31:0] wr_tim = ({16'h0, tim_cfg} & ~wmask) | (avs_writedata & wmask);
  wire [31:0] wr_pdr = (pdr_cfg & ~wmask) | (avs_writedata & wmask);
  wire [1:0]  clr_flt = (wr_go && sel_sts && avs_byteenable[0]) ?
                        avs_writedata[gds_pkg::STAT_FLT_LS:gds_pkg::STAT_FLT_HS] : 2'b00;
  wire [31:0] status = {20'h0, pre_dchr, pre_chr, 1'b0, locked, gate_fault_ls, gate_fault_hs};
  wire [31:0] rd_mux = sel_ctl ? {25'h0, ctrl} :
                       sel_cur ? {16'h0, cur_cfg} :
                       sel_tim ? {16'h0, tim_cfg} :
                       sel_pdr ? pdr_cfg :
                       sel_sts ? status :
                       sel_dly ? {last_toff, last_ton} : 32'h0;

  // A request is answered one cycle after it is first seen; the write lands
  // on the edge at which waitrequest is sampled low.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl    <= gds_pkg::CTRL_RESET;
      cur_cfg <= gds_pkg::CURRENT_RESET;
      tim_cfg <= gds_pkg::TIMING_RESET;
      pdr_cfg <= gds_pkg::PDR_RESET;
    end else if (wr_go) begin
      ctrl    <= sel_ctl ? wr_ctl[6:0] : ctrl;
      cur_cfg <= sel_cur ? wr_cur[15:0] : cur_cfg;
      tim_cfg <= sel_tim ? wr_tim[15:0] : tim_cfg;
      pdr_cfg <= sel_pdr ? wr_pdr : pdr_cfg;
    end
  end

  // ==========================================================================
  // Configuration fields
  wire        en        = ctrl[gds_pkg::CTRL_EN];
  wire [7:0]  drv_units = tim_cfg[gds_pkg::TIM_DRIVE +: 8];
  wire [7:0]  dead_cfg  = tim_cfg[gds_pkg::TIM_DEAD +: 8];
  wire [15:0] target    = pdr_cfg[gds_pkg::PDR_TARGET +: 16];
  wire [2:0]  kp        = pdr_cfg[gds_pkg::PDR_GAIN +: 3];
  wire [3:0]  pre_max   = pdr_cfg[gds_pkg::PDR_MAX +: 4];
  wire [3:0]  init_chr  = pdr_cfg[gds_pkg::PDR_INIT_CHR +: 4];
  wire [3:0]  init_dchr = pdr_cfg[gds_pkg::PDR_INIT_DCHR +: 4];
  wire [TW-1:0] drive_cycles = TW'(drv_units * gds_pkg::DRIVE_UNIT_CYCLES);
  wire        pdr_active = ctrl[gds_pkg::CTRL_PDR_EN] && ctrl[gds_pkg::CTRL_HB_MODE]
                           && SERIAL_VARIANT && (ctrl[gds_pkg::CTRL_SEL] == BRIDGE_INDEX[0]);

  // ==========================================================================
  // Break-before-make sequencing
  gds_bridge_type bs;
  gds_bridge_type next_bs;
  logic           tgt_high;
  logic [7:0]     dead_cnt;

  wire opp_off     = tgt_high ? !vgs_lo_s : !vgs_hi_s;
  wire want_change = !en || (pwm_s != tgt_high);
  wire make_now    = (bs == BR_DEAD) && (dead_cnt == 8'h00) && opp_off && !want_change;
  wire break_now   = (bs == BR_ON) && want_change;
  wire turn_on_hs  = make_now && tgt_high;
  wire turn_on_ls  = make_now && !tgt_high;
  wire turn_off_hs = break_now && tgt_high;
  wire turn_off_ls = break_now && !tgt_high;

  always_comb begin
    case (bs)
      BR_IDLE:  next_bs = en ? BR_BREAK : BR_IDLE;
      BR_BREAK: next_bs = !en ? BR_IDLE : (want_change || !opp_off) ? BR_BREAK : BR_DEAD;
      BR_DEAD:  next_bs = want_change ? BR_IDLE : make_now ? BR_ON : !opp_off ? BR_BREAK : BR_DEAD;
      BR_ON:    next_bs = want_change ? BR_IDLE : BR_ON;
      default:  next_bs = BR_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bs       <= BR_IDLE;
      tgt_high <= 1'b0;
      dead_cnt <= 8'h00;
    end else begin
      bs       <= next_bs;
      tgt_high <= (bs == BR_IDLE || bs == BR_BREAK) ? pwm_s : tgt_high;
      dead_cnt <= (next_bs != BR_DEAD) ? dead_cfg :
                  (dead_cnt != 8'h00) ? dead_cnt - 8'h01 : dead_cnt;
    end
  end

  // ==========================================================================
  // Delay reduction loop, high side taken as the drive switch
  logic        meas_on;
  logic        meas_off;
  logic [15:0] meas_cnt;

  wire on_done  = meas_on && sh_lo_s;
  wire off_done = meas_off && !sh_hi_s;

  function automatic logic [3:0] adapt_code(input logic [3:0] code, input logic [15:0] meas,
                                            input logic [15:0] tgt, input logic [2:0] gain,
                                            input logic [3:0] cmax);
    logic [15:0] mag;
    logic [18:0] prod;
    logic [4:0]  step;
    logic [4:0]  sum;
    mag  = (meas > tgt) ? meas - tgt : tgt - meas;
    prod = 19'(mag >> gds_pkg::ERR_SHIFT) * 19'(gain);
    step = (prod > 19'h0000f) ? 5'h0f : 5'(prod);
    if (meas > tgt) begin
      sum = 5'(code) + step;
    end else begin
      sum = (5'(code) > step) ? 5'(code) - step : 5'h00;
    end
    adapt_code = (sum > 5'(cmax)) ? cmax : sum[3:0];
  endfunction

  wire [3:0] init_chr_c  = (init_chr > pre_max) ? pre_max : init_chr;
  wire [3:0] init_dchr_c = (init_dchr > pre_max) ? pre_max : init_dchr;
  wire [3:0] adapt_chr   = adapt_code(pre_chr, meas_cnt, target, kp, pre_max);
  wire [3:0] adapt_dchr  = adapt_code(pre_dchr, meas_cnt, target, kp, pre_max);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meas_on  <= 1'b0;
      meas_off <= 1'b0;
      meas_cnt <= 16'h0000;
    end else begin
      meas_on  <= turn_on_hs || (meas_on && !on_done && !turn_off_hs);
      meas_off <= turn_off_hs || (meas_off && !off_done && !turn_on_hs);
      meas_cnt <= (turn_on_hs || turn_off_hs) ? 16'h0000 :
                  (meas_cnt != 16'hffff) ? meas_cnt + 16'h0001 : meas_cnt;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pre_chr   <= 4'h0;
      pre_dchr  <= 4'h0;
      locked    <= 1'b0;
      last_ton  <= 16'h0000;
      last_toff <= 16'h0000;
    end else if (!pdr_active) begin
      pre_chr  <= init_chr_c;
      pre_dchr <= init_dchr_c;
      locked   <= 1'b0;
    end else begin
      pre_chr   <= on_done ? adapt_chr : (pre_chr > pre_max ? pre_max : pre_chr);
      pre_dchr  <= off_done ? adapt_dchr : (pre_dchr > pre_max ? pre_max : pre_dchr);
      locked    <= locked || on_done || off_done;
      last_ton  <= on_done ? meas_cnt : last_ton;
      last_toff <= off_done ? meas_cnt : last_toff;
    end
  end

  // Pre-charge until the switch node starts to move, boost once it has settled.
  wire post_en = pdr_active && ctrl[gds_pkg::CTRL_POST_EN];
  wire post_on = post_en && hs_blank && hs_pull_up && sh_hi_s;
  wire post_dn = post_en && hs_blank && !hs_pull_up && !sh_lo_s;
  wire [3:0] hs_src_eff = (pdr_active && (meas_on || turn_on_hs)) ? pre_chr :
                          post_on ? gds_pkg::POST_CODE : cur_cfg[gds_pkg::CUR_HS_SRC +: 4];
  wire [3:0] hs_snk_eff = (pdr_active && (meas_off || turn_off_hs)) ? pre_dchr :
                          post_dn ? gds_pkg::POST_CODE : cur_cfg[gds_pkg::CUR_HS_SNK +: 4];

  // ==========================================================================
  // Drivers and fault flags
  logic hs_fault;
  logic ls_fault;

  // A sink window still running when the other side turns on drops to strong pulldown.
  wire hs_opp_sw = turn_on_ls || (ls_blank && ls_pull_up);
  wire ls_opp_sw = turn_on_hs || (hs_blank && hs_pull_up);

  gds_gate_driver #(.TW(TW)) u_hs (
    .clk_sys      (clk_sys),
    .resetn       (resetn),
    .turn_on      (turn_on_hs),
    .turn_off     (turn_off_hs),
    .gate_high    (vgs_hi_s),
    .low_range    (ctrl[gds_pkg::CTRL_HS_LO]),
    .src_code     (hs_src_eff),
    .snk_code     (hs_snk_eff),
    .drive_cycles (drive_cycles),
    .opp_switching (hs_opp_sw),
    .gate_current (hs_gate_current),
    .pull_up      (hs_pull_up),
    .in_drive     (hs_blank),
    .fault_pulse  (hs_fault)
  );

  gds_gate_driver #(.TW(TW)) u_ls (
    .clk_sys      (clk_sys),
    .resetn       (resetn),
    .turn_on      (turn_on_ls),
    .turn_off     (turn_off_ls),
    .gate_high    (vgs_lo_s),
    .low_range    (ctrl[gds_pkg::CTRL_LS_LO]),
    .src_code     (cur_cfg[gds_pkg::CUR_LS_SRC +: 4]),
    .snk_code     (cur_cfg[gds_pkg::CUR_LS_SNK +: 4]),
    .drive_cycles (drive_cycles),
    .opp_switching (ls_opp_sw),
    .gate_current (ls_gate_current),
    .pull_up      (ls_pull_up),
    .in_drive     (ls_blank),
    .fault_pulse  (ls_fault)
  );

  // A fault arriving with the clear wins so that no event is lost.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gate_fault_hs <= 1'b0;
      gate_fault_ls <= 1'b0;
    end else begin
      gate_fault_hs <= hs_fault || (gate_fault_hs && !clr_flt[0]);
      gate_fault_ls <= ls_fault || (gate_fault_ls && !clr_flt[1]);
    end
  end

  // ==========================================================================
  // Assertions
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence hs_make;
    turn_on_hs;
  endsequence

  sequence ls_make;
    turn_on_ls;
  endsequence

  break_make_a: assert property (hs_make |-> !vgs_lo_s ##1 hs_blank && hs_pull_up)
    else $error("high side enabled with low gate still on");
  break_make_ls_a: assert property (ls_make |-> !vgs_hi_s && bs == BR_DEAD)
    else $error("low side enabled with high gate still on");
  dead_time_a: assert property (bs == BR_DEAD && dead_cnt != 8'h00 |-> !make_now)
    else $error("switch enabled before dead time ended");
  strong_hold_a: assert property (hs_blank && hs_pull_up |-> ls_gate_current == gds_pkg::STRONG_CURRENT)
    else $error("off driver not in strong pulldown");
  loop_idle_a: assert property (!pdr_active |=> pre_chr == $past(init_chr_c) && !locked)
    else $error("delay loop moved while inactive");
  clamp_a: assert property (pdr_active && on_done |=> pre_chr <= $past(pre_max))
    else $error("pre-charge level above clamp");
  adapt_up_a: assert property (pdr_active && on_done && meas_cnt > target + 16'h0020 && kp != 3'h0
                               && pre_chr < pre_max |=> pre_chr > $past(pre_chr))
    else $error("slow turn-on did not raise pre-charge");
  post_boost_a: assert property (post_on && !meas_on |-> hs_src_eff == gds_pkg::POST_CODE)
    else $error("no post-charge boost");
  fault_sticky_a: assert property (hs_fault ##1 !clr_flt[0] [*3] |-> gate_fault_hs)
    else $error("gate fault flag lost");

endmodule

// ==== tb/gds_bridge_model.sv ====
// Behavioural half-bridge power stage seen by the sequencer.
`timescale 1ns/1ps
module gds_bridge_model (
  input  wire logic clk_sys,      // Clock.
  input  wire logic hs_pull_up,   // High-side sourcing.
  input  wire logic ls_pull_up,   // Low-side sourcing.
  input  wire logic stuck_low,    // Pins the high gate low.
  output logic      vgs_high_on,  // High gate on.
  output logic      vgs_low_on,   // Low gate on.
  output logic      sh_above_low, // Node above low level.
  output logic      sh_above_high // Node above high level.
);
  // Gates settle in 4 cycles, well inside the 20-cycle window, so no false faults.
  logic [3:0] hs_q = 4'h0;
  logic [3:0] ls_q = 4'h0;
  always @(posedge clk_sys) begin
    hs_q <= {hs_q[2:0], hs_pull_up & !stuck_low};
    ls_q <= {ls_q[2:0], ls_pull_up};
  end
  assign vgs_high_on = hs_q[3];
  assign vgs_low_on = ls_q[3];
  assign sh_above_low = hs_q[3];
  assign sh_above_high = hs_q[3];
endmodule

// ==== tb/gds_testbench.sv ====
// Self-checking bench for the gate drive sequencer.
`timescale 1ns/1ps
module testbench;
  // ==========================================================================
  // Wiring
  logic        clk_sys = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic        pwm_in = 1'b0, stuck_low = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic        avs_waitrequest, vgs_high_on, vgs_low_on, sh_above_low, sh_above_high;
  logic        hs_pull_up, ls_pull_up, hs_blank, ls_blank, gate_fault_hs, gate_fault_ls;
  logic [13:0] hs_gate_current, ls_gate_current;
  int          failures = 0, checks = 0, n;
  typedef struct {logic w; logic [4:0] a; logic [31:0] d, e;} gds_row_type;
  gds_row_type rows [10] = '{'{0, 5'h00, 0, 0}, '{0, 5'h04, 0, 32'h8888},
    '{0, 5'h08, 0, 32'ha}, '{0, 5'h0c, 0, 32'h4f4200a0}, '{1, 5'h18, 32'hff, 0},
    '{0, 5'h18, 0, 0}, '{1, 5'h08, 32'h1, 0}, '{0, 5'h08, 0, 32'h1},
    '{1, 5'h04, 32'h1203, 0}, '{0, 5'h04, 0, 32'h1203}};
  always #2.5 clk_sys = ~clk_sys;
  gds_sequencer dut_u (.clk_sys, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .pwm_in, .vgs_high_on, .vgs_low_on,
    .sh_above_low, .sh_above_high, .hs_gate_current, .hs_pull_up, .hs_blank, .ls_gate_current,
    .ls_pull_up, .ls_blank, .gate_fault_hs, .gate_fault_ls);
  gds_bridge_model bm_u (.clk_sys, .hs_pull_up, .ls_pull_up, .stuck_low, .vgs_high_on,
    .vgs_low_on, .sh_above_low, .sh_above_high);
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  // Waits sample on the falling edge, where registered outputs have settled.
  task automatic till(ref logic s, input logic v);
    n = 0;
    while (s !== v) begin
      @(negedge clk_sys);
      n++;
      if (n > 2000) begin
        failures++;
        tally_and_finish();
      end
    end
  endtask
  // The bus is sampled on rising edges only; data is taken where waitrequest is low.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (n > 2000) begin
        failures++;
        tally_and_finish();
      end
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic set_pwm(input logic v);
    @(posedge clk_sys);
    pwm_in <= v;
  endtask
  // ==========================================================================
  // Sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    chk("reset current", gds_pkg::STRONG_CURRENT, hs_gate_current);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk("readdata", rows[i].e, q);
    end
    $display("register rows done");
    bus(1'b1, gds_pkg::OFS_CTRL, 32'h1);
    till(ls_pull_up, 1'b1);
    till(ls_blank, 1'b0);
    set_pwm(1'b1);
    till(hs_pull_up, 1'b1);
    chk("peak", gds_pkg::CUR_NORMAL[3], hs_gate_current);
    chk("opposite", gds_pkg::STRONG_CURRENT, ls_gate_current);
    chk("opposite gate", 0, vgs_low_on);
    till(hs_blank, 1'b0);
    chk("window", 20, n);
    chk("hold", gds_pkg::HOLD_CURRENT, hs_gate_current);
    bus(1'b1, gds_pkg::OFS_CTRL, 32'h21);
    set_pwm(1'b0);
    till(ls_pull_up, 1'b1);
    set_pwm(1'b1);
    till(hs_pull_up, 1'b1);
    chk("low range", gds_pkg::CUR_LOW[3], hs_gate_current);
    set_pwm(1'b0);
    till(hs_pull_up, 1'b0);
    chk("early end", 1, n < 8);
    chk("no fault", 0, gate_fault_hs);
    $display("drive test done");
    till(hs_blank, 1'b0);
    set_pwm(1'b1);
    stuck_low <= 1'b1;
    till(hs_pull_up, 1'b1);
    till(hs_blank, 1'b0);
    repeat (2) @(negedge clk_sys);
    chk("fault", 1, gate_fault_hs);
    chk("ls fault", 0, gate_fault_ls);
    bus(1'b0, gds_pkg::OFS_STATUS, 0);
    chk("status", 1, q[0]);
    bus(1'b1, gds_pkg::OFS_STATUS, 32'h1);
    @(negedge clk_sys);
    chk("cleared", 0, gate_fault_hs);
    $display("fault test done");
    bus(1'b1, gds_pkg::OFS_CTRL, 32'hf);
    set_pwm(1'b0);
    stuck_low <= 1'b0;
    till(ls_pull_up, 1'b1);
    till(ls_blank, 1'b0);
    set_pwm(1'b1);
    till(hs_pull_up, 1'b1);
    chk("precharge", gds_pkg::CUR_NORMAL[4], hs_gate_current);
    repeat (12) @(negedge clk_sys);
    chk("boost", gds_pkg::CUR_NORMAL[15], hs_gate_current);
    bus(1'b0, gds_pkg::OFS_STATUS, 0);
    chk("charge code", 32'h0, q[7:4]);
    chk("discharge code", 32'h0, q[11:8]);
    chk("locked", 1, q[2]);
    $display("delay loop test done");
    tally_and_finish();
  end
endmodule
